// File: verilog/tic_ctrl.sv
/*
 * time interval counter control: time registers (1/128 s, seconds, minutes,
 * hours), an 8-bit interval counter with target match, and the control
 * register, all on the special-function register port.
 * assumes the core drives the port on core_clk, por_n is the power-on reset
 * and rstn the system reset; the interrupt controller lies outside.
 */
// What this block does
// - day wrap set: hours count 0 to 23
// - day wrap clear: hours count 0 to 255
// - system reset leaves time registers running
// - system reset clears the day wrap bit
// - base field picks interval counter tick source
// - single shot: timeout clears interval count enable
// - otherwise counter reloads and restarts on timeout
// - counter stepping to target value sets match flag
// - count enable lets counter advance per tick
// - count enable low stops and zeroes counter
// - clock enable gates 1/128 s tick through
// - clock enable clear stops and zeroes time
// - time registers writable while clock enable low
// - fraction counts 0 to 127, carries to seconds
// - seconds, minutes count 0 to 59 with carry
// - interval counter steps each time the selected register advances
`timescale 1ns/1ps
module tic_ctrl #(
    parameter int unsigned TICK_CYCLES = tic_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic por_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic interval_match_flag
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic day_wrap_select_reg;
    logic [1:0] interval_base_sel_reg;
    logic single_shot_select_reg;
    logic interval_match_flag_reg;
    logic interval_count_enable_reg;
    logic timekeeping_clock_enable_reg;
    logic [7:0] fraction_tick_count_reg;
    logic [7:0] seconds_reg;
    logic [7:0] minutes_reg;
    logic [7:0] hours_reg;
    logic [7:0] interval_target_reg;
    logic [7:0] interval_count_reg;
    logic [7:0] sfr_rdata_reg;

    logic base_tick;
    logic run_tick;
    logic frac_wrap;
    logic sec_wrap;
    logic min_wrap;
    logic hour_wrap;
    logic interval_tick;
    logic timeout;
    logic [7:0] hour_limit;
    logic [7:0] interval_count_next;
    logic wr_ctrl;
    logic wr_frac;
    logic wr_sec;
    logic wr_min;
    logic wr_hour;
    logic wr_target;
    logic time_wr_ok;
    logic clock_stop;
    tic_pkg::tic_base_type base_sel;

    // ------------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------------
    tic_tick_div #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick_div (
        .core_clk(core_clk),
        .por_n(por_n),
        .tick(base_tick)
    );

    // ------------------------------------------------------------------
    // register port decode
    // ------------------------------------------------------------------
    assign wr_ctrl = sfr_wr && (sfr_addr == tic_pkg::CTRL_ADDR);
    assign wr_frac = sfr_wr && (sfr_addr == tic_pkg::FRAC_ADDR);
    assign wr_sec = sfr_wr && (sfr_addr == tic_pkg::SEC_ADDR);
    assign wr_min = sfr_wr && (sfr_addr == tic_pkg::MIN_ADDR);
    assign wr_hour = sfr_wr && (sfr_addr == tic_pkg::HOUR_ADDR);
    assign wr_target = sfr_wr && (sfr_addr == tic_pkg::TARGET_ADDR);

    assign time_wr_ok = !timekeeping_clock_enable_reg;
    // falling edge of the clock enable written by software
    assign clock_stop = wr_ctrl && timekeeping_clock_enable_reg
                        && !sfr_wdata[tic_pkg::CLOCK_EN_BIT];

    // ------------------------------------------------------------------
    // time register carry chain
    // ------------------------------------------------------------------
    assign run_tick = base_tick && timekeeping_clock_enable_reg;
    assign frac_wrap = run_tick && (fraction_tick_count_reg == tic_pkg::FRAC_MAX);
    assign sec_wrap = frac_wrap && (seconds_reg == tic_pkg::SEC_MAX);
    assign min_wrap = sec_wrap && (minutes_reg == tic_pkg::MIN_MAX);
    assign hour_limit = day_wrap_select_reg ? tic_pkg::HOUR_DAY_MAX : tic_pkg::HOUR_FULL_MAX;
    assign hour_wrap = min_wrap && (hours_reg == hour_limit);

    // ------------------------------------------------------------------
    // interval counter source and match
    // ------------------------------------------------------------------
    assign base_sel = tic_pkg::tic_base_type'(interval_base_sel_reg);

    always_comb begin
        case (base_sel)
            tic_pkg::BASE_FRAC: begin
                interval_tick = run_tick;
            end
            tic_pkg::BASE_SEC: begin
                interval_tick = frac_wrap;
            end
            tic_pkg::BASE_MIN: begin
                interval_tick = sec_wrap;
            end
            tic_pkg::BASE_HOUR: begin
                interval_tick = min_wrap;
            end
            default: begin
                interval_tick = 1'b0;
            end
        endcase
    end

    assign interval_count_next = 8'(interval_count_reg + 8'h01);
    assign timeout = interval_tick && interval_count_enable_reg
                     && (interval_count_next == interval_target_reg);

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    // only field cleared by the system reset
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            day_wrap_select_reg <= 1'b0;
        end else if (!rstn) begin
            day_wrap_select_reg <= 1'b0;
        end else if (wr_ctrl) begin
            day_wrap_select_reg <= sfr_wdata[tic_pkg::DAY_WRAP_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            interval_base_sel_reg <= tic_pkg::BASE_RESET;
            single_shot_select_reg <= 1'b0;
            timekeeping_clock_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            interval_base_sel_reg <= sfr_wdata[tic_pkg::BASE_HI_BIT:tic_pkg::BASE_LO_BIT];
            single_shot_select_reg <= sfr_wdata[tic_pkg::SINGLE_SHOT_BIT];
            timekeeping_clock_enable_reg <= sfr_wdata[tic_pkg::CLOCK_EN_BIT];
        end
    end

    // a software write in the timeout cycle wins, so a fresh enable is kept
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            interval_count_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            interval_count_enable_reg <= sfr_wdata[tic_pkg::COUNT_EN_BIT];
        end else if (timeout && single_shot_select_reg) begin
            interval_count_enable_reg <= 1'b0;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            interval_match_flag_reg <= 1'b0;
        end else if (timeout) begin
            interval_match_flag_reg <= 1'b1;
        end else if (wr_ctrl) begin
            interval_match_flag_reg <= sfr_wdata[tic_pkg::MATCH_FLAG_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            interval_target_reg <= tic_pkg::REG_RESET;
        end else if (wr_target) begin
            interval_target_reg <= sfr_wdata;
        end
    end

    // ------------------------------------------------------------------
    // interval counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            interval_count_reg <= tic_pkg::REG_RESET;
        end else if (!interval_count_enable_reg) begin
            interval_count_reg <= tic_pkg::REG_RESET;
        end else if (timeout) begin
            interval_count_reg <= tic_pkg::REG_RESET;
        end else if (interval_tick) begin
            interval_count_reg <= interval_count_next;
        end
    end

    // ------------------------------------------------------------------
    // time registers: not touched by the system reset
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            fraction_tick_count_reg <= tic_pkg::REG_RESET;
        end else if (clock_stop) begin
            fraction_tick_count_reg <= tic_pkg::REG_RESET;
        end else if (wr_frac && time_wr_ok) begin
            fraction_tick_count_reg <= sfr_wdata & tic_pkg::FRAC_MASK;
        end else if (run_tick) begin
            fraction_tick_count_reg <= tic_pkg::tic_wrap_inc(fraction_tick_count_reg, tic_pkg::FRAC_MAX);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            seconds_reg <= tic_pkg::REG_RESET;
        end else if (clock_stop) begin
            seconds_reg <= tic_pkg::REG_RESET;
        end else if (wr_sec && time_wr_ok) begin
            seconds_reg <= sfr_wdata;
        end else if (frac_wrap) begin
            seconds_reg <= tic_pkg::tic_wrap_inc(seconds_reg, tic_pkg::SEC_MAX);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            minutes_reg <= tic_pkg::REG_RESET;
        end else if (clock_stop) begin
            minutes_reg <= tic_pkg::REG_RESET;
        end else if (wr_min && time_wr_ok) begin
            minutes_reg <= sfr_wdata;
        end else if (sec_wrap) begin
            minutes_reg <= tic_pkg::tic_wrap_inc(minutes_reg, tic_pkg::MIN_MAX);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            hours_reg <= tic_pkg::REG_RESET;
        end else if (clock_stop) begin
            hours_reg <= tic_pkg::REG_RESET;
        end else if (wr_hour && time_wr_ok) begin
            hours_reg <= sfr_wdata;
        end else if (hour_wrap) begin
            hours_reg <= tic_pkg::REG_RESET;
        end else if (min_wrap) begin
            hours_reg <= 8'(hours_reg + 8'h01);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!por_n || !rstn) begin
            sfr_rdata_reg <= tic_pkg::REG_RESET;
        end else if (sfr_rd) begin
            case (sfr_addr)
                tic_pkg::CTRL_ADDR: begin
                    sfr_rdata_reg <= {1'b0, day_wrap_select_reg, interval_base_sel_reg,
                                      single_shot_select_reg, interval_match_flag_reg,
                                      interval_count_enable_reg, timekeeping_clock_enable_reg};
                end
                tic_pkg::FRAC_ADDR: begin
                    sfr_rdata_reg <= fraction_tick_count_reg;
                end
                tic_pkg::SEC_ADDR: begin
                    sfr_rdata_reg <= seconds_reg;
                end
                tic_pkg::MIN_ADDR: begin
                    sfr_rdata_reg <= minutes_reg;
                end
                tic_pkg::HOUR_ADDR: begin
                    sfr_rdata_reg <= hours_reg;
                end
                tic_pkg::TARGET_ADDR: begin
                    sfr_rdata_reg <= interval_target_reg;
                end
                default: begin
                    sfr_rdata_reg <= tic_pkg::REG_RESET;
                end
            endcase
        end
    end

    assign sfr_rdata = sfr_rdata_reg;
    assign interval_match_flag = interval_match_flag_reg;

endmodule // tic_ctrl

// File: pkg/tic_pkg.sv
/*
 * constants, types and helpers for the time interval counter control block:
 * special-function register addresses, control bit positions, counter limits
 * and the 1/128 second timebase figures.
 * assumes a 100 MHz core clock and an 8-bit special-function register port.
 */
package tic_pkg;

    // ------------------------------------------------------------------
    // special-function register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'hA1;
    localparam logic [7:0] FRAC_ADDR = 8'hA2;
    localparam logic [7:0] SEC_ADDR = 8'hA3;
    localparam logic [7:0] MIN_ADDR = 8'hA4;
    localparam logic [7:0] HOUR_ADDR = 8'hA5;
    localparam logic [7:0] TARGET_ADDR = 8'hA6;

    // ------------------------------------------------------------------
    // interval_clock_control field positions
    // ------------------------------------------------------------------
    localparam int DAY_WRAP_BIT = 6;
    localparam int BASE_HI_BIT = 5;
    localparam int BASE_LO_BIT = 4;
    localparam int SINGLE_SHOT_BIT = 3;
    localparam int MATCH_FLAG_BIT = 2;
    localparam int COUNT_EN_BIT = 1;
    localparam int CLOCK_EN_BIT = 0;

    // ------------------------------------------------------------------
    // reset values and counter limits
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] BASE_RESET = 2'h0;
    localparam logic [7:0] FRAC_MASK = 8'h7F;
    localparam logic [7:0] FRAC_MAX = 8'h7F;
    localparam logic [7:0] SEC_MAX = 8'h3B;
    localparam logic [7:0] MIN_MAX = 8'h3B;
    localparam logic [7:0] HOUR_DAY_MAX = 8'h17;
    localparam logic [7:0] HOUR_FULL_MAX = 8'hFF;

    // ------------------------------------------------------------------
    // timebase: 1/128 second from the core clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 7812500;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // interval counter update source
    typedef enum logic [1:0] {
        BASE_FRAC,
        BASE_SEC,
        BASE_MIN,
        BASE_HOUR
    } tic_base_type;

    // one step of a counter that returns to zero after its limit
    function automatic logic [7:0] tic_wrap_inc(input logic [7:0] value, input logic [7:0] limit);
        tic_wrap_inc = (value == limit) ? 8'h00 : 8'(value + 8'h01);
    endfunction

endpackage

// File: verilog/tic_tick_div.sv
/*
 * divider that turns the core clock into a one-cycle 1/128 second enable.
 * assumes tick_cycles of at least 2; runs from power-on reset only so that
 * a system reset does not disturb the timebase.
 */
`timescale 1ns/1ps
module tic_tick_div #(
    parameter int unsigned TICK_CYCLES = 781250
) (
    input wire logic core_clk,
    input wire logic por_n,
    output logic tick
);

    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic tick_reg;

    // ------------------------------------------------------------------
    // free-running divider
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            count_reg <= CW'(count_reg + 1'b1);
            tick_reg <= 1'b0;
        end
    end

    assign tick = tick_reg;

endmodule // tic_tick_div

// File: test/tic_ctrl_chk.sv
/*
 * port checker for the time interval counter control block.
 * assumes it is bound to tic_ctrl; power-on reset disables every check.
 */
`timescale 1ns/1ps
module tic_ctrl_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic por_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic interval_match_flag
);
    logic clk_en_reg;
    logic pre_ok_reg;
    logic [7:0] pre_reg;
    logic [7:0] pre_addr_reg;
    logic [7:0] tgt_reg;
    logic ctrl_wr;
    logic time_wr;
    assign ctrl_wr = sfr_wr && sfr_addr == tic_pkg::CTRL_ADDR;
    assign time_wr = sfr_wr && sfr_addr >= tic_pkg::SEC_ADDR && sfr_addr <= tic_pkg::HOUR_ADDR;
    // --------------------------------
    // shadows of what software wrote
    // --------------------------------
    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            clk_en_reg <= 1'b0;
            pre_ok_reg <= 1'b0;
            pre_reg <= 8'h00;
            pre_addr_reg <= 8'h00;
            tgt_reg <= 8'h00;
        end else begin
            if (ctrl_wr) begin
                clk_en_reg <= sfr_wdata[0];
            end
            if (sfr_wr && sfr_addr == tic_pkg::TARGET_ADDR) begin
                tgt_reg <= sfr_wdata;
            end
            if (time_wr && !clk_en_reg) begin
                pre_reg <= sfr_wdata;
                pre_addr_reg <= sfr_addr;
            end
            pre_ok_reg <= (time_wr && !clk_en_reg) || (pre_ok_reg && !ctrl_wr && !time_wr);
        end
    end
    // --------------------------------
    // properties
    // --------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!por_n);
    sequence s_rd(logic [7:0] a);
        rstn && sfr_rd && sfr_addr == a;
    endsequence
    sequence s_stop;
        ctrl_wr && !sfr_wdata[0] && clk_en_reg;
    endsequence
    sequence s_rd_time;
        rstn && sfr_rd && sfr_addr >= tic_pkg::FRAC_ADDR && sfr_addr <= tic_pkg::HOUR_ADDR;
    endsequence
    AST_FLAG_FALL: assert property ($fell(interval_match_flag) |-> $past(ctrl_wr && !sfr_wdata[2]))
        else $error("match flag fell without a software clear");
    AST_BIT7_ZERO: assert property (s_rd(tic_pkg::CTRL_ADDR) |=> !sfr_rdata[7])
        else $error("control bit 7 read as one");
    AST_FRAC_RANGE: assert property (s_rd(tic_pkg::FRAC_ADDR) |=> sfr_rdata <= tic_pkg::FRAC_MAX)
        else $error("fraction out of range");
    AST_SEC_RANGE: assert property (s_rd(tic_pkg::SEC_ADDR) |=> sfr_rdata <= tic_pkg::SEC_MAX)
        else $error("seconds out of range");
    AST_TARGET_RB: assert property (s_rd(tic_pkg::TARGET_ADDR) |=> sfr_rdata == $past(tgt_reg))
        else $error("target readback wrong");
    AST_DAY_WRAP_CLR: assert property ($rose(rstn) ##1 s_rd(tic_pkg::CTRL_ADDR) |=> !sfr_rdata[6])
        else $error("day wrap select survived system reset");
    AST_TIME_CLEAR: assert property (s_stop ##1 !sfr_wr ##1 s_rd_time |=> sfr_rdata == 8'h00)
        else $error("time register not cleared on clock stop");
    AST_TIME_PRELOAD: assert property (rstn && sfr_rd && pre_ok_reg && sfr_addr == pre_addr_reg
        |=> sfr_rdata == $past(pre_reg))
        else $error("preloaded time value lost");
endmodule // tic_ctrl_chk

bind tic_ctrl tic_ctrl_chk chk_u (.core_clk(core_clk), .rstn(rstn), .por_n(por_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .interval_match_flag(interval_match_flag));

// File: test/tb_tic_ctrl.sv
/*
 * self-checking bench for tic_ctrl: drives the register port, queues expected reads.
 * assumes the checker is bound separately; the tick is shortened to 4 cycles.
 */
`timescale 1ns/1ps
`define CHK(name, seen, exp) begin cmp_count++; if ((seen) !== (exp)) begin errors++; \
    $display("unexpected %s: expected %h seen %h", name, exp, seen); end end
module tb_tic_ctrl;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic por_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic interval_match_flag;
    logic rd_seen = 1'b0;
    logic [23:0] note_q[$];
    logic [23:0] nt;
    logic [7:0] hin [3] = '{8'h17, 8'h17, 8'hFF};
    logic [7:0] hexp [3] = '{8'h00, 8'h18, 8'h00};
    logic [31:0] v;
    logic [1:0] b;
    int seed;
    int errors = 0;
    int cmp_count = 0;
    int i;
    always #5 core_clk = ~core_clk;
    tic_ctrl #(.TICK_CYCLES(4)) dut_u (.core_clk(core_clk), .rstn(rstn), .por_n(por_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .interval_match_flag(interval_match_flag));
    // --------------------------------
    // port tasks
    // --------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        note_q.push_back({a, m, e});
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // --------------------------------
    // read monitor
    // --------------------------------
    always @(posedge core_clk) rd_seen <= sfr_rd;
    always @(negedge core_clk) begin
        if (rd_seen) begin
            nt = note_q.pop_front();
            `CHK("rdata", sfr_rdata & nt[15:8], nt[7:0] & nt[15:8])
            if (nt[23:16] == tic_pkg::CTRL_ADDR && nt[10]) begin
                `CHK("flag", interval_match_flag, nt[2])
            end
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        summarize();
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        seed = 32'hb080;
        repeat (12) @(posedge core_clk);
        por_n <= 1'b1;
        rstn <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(8'(8'hA0 + i), 8'h00, 8'hFF);
        end
        wr(tic_pkg::CTRL_ADDR, 8'h80);
        rd(tic_pkg::CTRL_ADDR, 8'h00, 8'hFF);
        $display("test reset and map done");
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(tic_pkg::FRAC_ADDR, v[7:0]);
            rd(tic_pkg::FRAC_ADDR, v[7:0] & tic_pkg::FRAC_MASK, 8'hFF);
            wr(tic_pkg::SEC_ADDR, v[15:8] % 8'h3B);
            rd(tic_pkg::SEC_ADDR, v[15:8] % 8'h3B, 8'hFF);
            wr(tic_pkg::HOUR_ADDR, v[31:24]);
            rd(tic_pkg::HOUR_ADDR, v[31:24], 8'hFF);
            wr(tic_pkg::TARGET_ADDR, v[23:16]);
            rd(tic_pkg::TARGET_ADDR, v[23:16], 8'hFF);
        end
        $display("test preload done");
        for (i = 0; i < 3; i++) begin
            wr(tic_pkg::CTRL_ADDR, 8'h00);
            wr(tic_pkg::FRAC_ADDR, 8'h7E);
            wr(tic_pkg::SEC_ADDR, 8'h3B);
            wr(tic_pkg::MIN_ADDR, 8'h3B);
            wr(tic_pkg::HOUR_ADDR, hin[i]);
            wr(tic_pkg::CTRL_ADDR, (i == 0) ? 8'h41 : 8'h01);
            repeat (8) @(posedge core_clk);
            rd(tic_pkg::FRAC_ADDR, 8'h00, 8'hFE);
            rd(tic_pkg::SEC_ADDR, 8'h00, 8'hFF);
            rd(tic_pkg::MIN_ADDR, 8'h00, 8'hFF);
            rd(tic_pkg::HOUR_ADDR, hexp[i], 8'hFF);
        end
        wr(tic_pkg::CTRL_ADDR, 8'h00);
        rd(tic_pkg::FRAC_ADDR, 8'h00, 8'hFF);
        rd(tic_pkg::HOUR_ADDR, 8'h00, 8'hFF);
        $display("test time chain done");
        for (i = 0; i < 4; i++) begin
            b = 2'(i);
            wr(tic_pkg::CTRL_ADDR, 8'h00);
            wr(tic_pkg::FRAC_ADDR, 8'h7E);
            wr(tic_pkg::SEC_ADDR, (i >= 2) ? 8'h3B : 8'h00);
            wr(tic_pkg::MIN_ADDR, (i == 3) ? 8'h3B : 8'h00);
            wr(tic_pkg::TARGET_ADDR, (i == 0) ? 8'h02 : 8'h01);
            wr(tic_pkg::CTRL_ADDR, {2'b00, b, 4'h3});
            rd(tic_pkg::CTRL_ADDR, {2'b00, b, 4'h3}, 8'hFF);
            repeat (6) @(posedge core_clk);
            rd(tic_pkg::CTRL_ADDR, {2'b00, b, 4'h7}, 8'hFF);
        end
        $display("test timebase select done");
        wr(tic_pkg::CTRL_ADDR, 8'h00);
        wr(tic_pkg::CTRL_ADDR, 8'h0B);
        repeat (8) @(posedge core_clk);
        rd(tic_pkg::CTRL_ADDR, 8'h0D, 8'hFF);
        repeat (8) @(posedge core_clk);
        rd(tic_pkg::CTRL_ADDR, 8'h0D, 8'hFF);
        wr(tic_pkg::CTRL_ADDR, 8'h03);
        repeat (8) @(posedge core_clk);
        rd(tic_pkg::CTRL_ADDR, 8'h07, 8'hFF);
        wr(tic_pkg::CTRL_ADDR, 8'h01);
        wr(tic_pkg::CTRL_ADDR, 8'h01);
        rd(tic_pkg::CTRL_ADDR, 8'h01, 8'hFF);
        wr(tic_pkg::TARGET_ADDR, 8'h05);
        wr(tic_pkg::CTRL_ADDR, 8'h03);
        repeat (13) @(posedge core_clk);
        wr(tic_pkg::CTRL_ADDR, 8'h01);
        wr(tic_pkg::CTRL_ADDR, 8'h03);
        repeat (11) @(posedge core_clk);
        rd(tic_pkg::CTRL_ADDR, 8'h03, 8'hFF);
        repeat (8) @(posedge core_clk);
        rd(tic_pkg::CTRL_ADDR, 8'h07, 8'hFF);
        wr(tic_pkg::SEC_ADDR, 8'h07);
        rd(tic_pkg::SEC_ADDR, 8'h00, 8'hFF);
        $display("test interval counter done");
        wr(tic_pkg::CTRL_ADDR, 8'h00);
        wr(tic_pkg::HOUR_ADDR, 8'h05);
        wr(tic_pkg::CTRL_ADDR, 8'h41);
        @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        rstn <= 1'b1;
        rd(tic_pkg::CTRL_ADDR, 8'h01, 8'hFF);
        rd(tic_pkg::HOUR_ADDR, 8'h05, 8'hFF);
        wr(tic_pkg::CTRL_ADDR, 8'h41);
        rd(tic_pkg::CTRL_ADDR, 8'h41, 8'hFF);
        $display("test system reset done");
        repeat (2) @(posedge core_clk);
        summarize();
    end
endmodule // tb_tic_ctrl
